// ===== design/cms_pkg.sv
`default_nettype none
package cms_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] CMS_OFF_STATUS    = 8'h00;
	localparam logic [7:0] CMS_OFF_TRIM      = 8'h04;
	localparam logic [7:0] CMS_OFF_CTRL_TWO  = 8'h08;
	localparam logic [7:0] CMS_OFF_CTRL_ONE  = 8'h0c;
	localparam logic [7:0] CMS_OFF_CTRL_THR  = 8'h10;

	// Field positions
	localparam int CMS_SRC_HI    = 7;
	localparam int CMS_SRC_LO    = 6;
	localparam int CMS_REFERENCE_DIVIDER_HI   = 5;
	localparam int CMS_REFERENCE_DIVIDER_LO   = 3;
	localparam int CMS_IREF_BIT  = 2;
	localparam int CMS_IRCLK_BIT = 1;
	localparam int CMS_BUS_DIVIDER_HI   = 7;
	localparam int CMS_BUS_DIVIDER_LO   = 6;
	localparam int CMS_RANGE_BIT = 5;
	localparam int CMS_HGO_BIT   = 4;
	localparam int CMS_LP_BIT    = 3;
	localparam int CMS_XTAL_BIT  = 2;
	localparam int CMS_EREN_BIT  = 1;
	localparam int CMS_LOOP_BIT  = 6;
	localparam int CMS_LOOP_MULTIPLIER_HI   = 3;
	localparam int CMS_LOOP_MULTIPLIER_LO   = 0;
	localparam int CMS_FINE_TRIM_BIT_BIT = 0;

	// Reset values
	localparam logic [1:0] CMS_RST_SRC  = 2'h0;
	localparam logic [2:0] CMS_RST_REFERENCE_DIVIDER = 3'h0;
	localparam logic [1:0] CMS_RST_BUS_DIVIDER = 2'h1;
	localparam logic [3:0] CMS_RST_LOOP_MULTIPLIER = 4'h1;
	localparam logic [7:0] CMS_RST_TRIM = 8'h80;

	// Source select and source status codes
	localparam logic [1:0] CMS_SRC_LOOP = 2'h0;
	localparam logic [1:0] CMS_SRC_INT  = 2'h1;
	localparam logic [1:0] CMS_SRC_EXT  = 2'h2;
	localparam logic [1:0] CMS_SRC_PLL  = 2'h3;

	localparam logic [1:0] CMS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CMS_RESP_SLVERR = 2'h2;

	// Timing
	localparam int CMS_CLK_KHZ           = 20000;
	localparam int CMS_IREF_STAB_US      = 100;
	localparam int CMS_FLL_LOCK_MS       = 1;
	localparam int CMS_IREF_STAB_CYCLES  = CMS_IREF_STAB_US * CMS_CLK_KHZ / 1000;
	localparam int CMS_LOCK_CYCLES       = CMS_FLL_LOCK_MS * CMS_CLK_KHZ;
	localparam int CMS_SRC_SWITCH_CYCLES = 4;
	localparam logic [10:0] CMS_FLL_FACTOR = 11'h400;

	typedef enum logic [2:0] {
		CMS_IDX_STATUS, CMS_IDX_TRIM, CMS_IDX_CTRL_TWO, CMS_IDX_CTRL_ONE,
		CMS_IDX_CTRL_THR, CMS_IDX_NONE
	} cms_idx_t;

	typedef enum logic [2:0] {
		CMS_FLL_ENGAGED_INTERNAL, CMS_FLL_ENGAGED_EXTERNAL, CMS_FLL_BYPASSED_EXTERNAL,
		CMS_FLL_BYPASSED_INTERNAL, CMS_PLL_ENGAGED_EXTERNAL, CMS_PLL_BYPASSED_EXTERNAL,
		CMS_LOW_POWER_BYPASSED_INTERNAL, CMS_LOW_POWER_BYPASSED_EXTERNAL
	} cms_mode_t;

	typedef enum {CMS_SW_IDLE, CMS_SW_SETTLE} cms_sw_state_t;
endpackage : cms_pkg
`default_nettype wire

// ===== design/cms_clock_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module cms_clock_mode_sequencer
	import cms_pkg::*;
#(
	parameter int LOCK_CYCLES = CMS_LOCK_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        osc_stable_pin,
	input  wire logic        debug_active_pin,
	output var  cms_mode_t   clock_mode,
	output var  logic [1:0]  active_source,
	output var  logic [10:0] freq_multiplier,
	output var  logic [10:0] freq_divisor,
	output var  logic [11:0] bus_divisor,
	output var  logic        fll_enable,
	output var  logic        pll_enable,
	output var  logic        internal_ref_enable,
	output var  logic        external_ref_enable,
	output var  logic        crystal_select,
	output var  logic        high_gain_oscillator,
	output var  logic        osc_range_high,
	output var  logic [7:0]  coarse_trim_value,
	output var  logic        fine_trim_bit
);
	// Software visible control fields
	logic [1:0]    source_select;
	logic [2:0]    reference_divider;
	logic          internal_ref_select;
	logic [1:0]    bus_divider;
	logic          low_power_bypass;
	logic          external_ref_en;
	logic          loop_select;
	logic [3:0]    loop_multiplier;
	// Hardware state
	logic          oscillator_ready;
	logic          lock;
	logic          loop_select_status;
	logic          ref_status;
	logic [1:0]    source_status;
	logic [2:0]    applied_reference_divider;
	logic [3:0]    applied_loop_multiplier;
	logic          applied_loop;
	logic [11:0]   iref_count;
	logic          iref_stable;
	logic [23:0]   lock_count;
	logic [8:0]    lock_cfg_prev;
	logic [7:0]    ref_count;
	logic [7:0]    sw_count;
	logic [1:0]    sw_target;
	cms_sw_state_t sw_state;
	logic [1:0]    osc_sync;
	logic [1:0]    dbg_sync;
	// Bus slave state
	logic [7:0]    aw_addr;
	logic          aw_full;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic          w_full;
	// Combinational helpers
	logic          lp_eff;
	logic          ext_on;
	logic          ext_avail;
	logic          ref_ok;
	logic [1:0]    next_target;
	logic          target_avail;
	logic [8:0]    lock_cfg;
	cms_mode_t     next_mode;
	logic [10:0]   next_mult;
	logic [10:0]   next_div;
	logic [10:0]   r_factor;
	logic [10:0]   b_factor;

	function automatic cms_idx_t reg_index(input logic [7:0] addr);
		if (addr == CMS_OFF_STATUS) begin
			return CMS_IDX_STATUS;
		end else if (addr == CMS_OFF_TRIM) begin
			return CMS_IDX_TRIM;
		end else if (addr == CMS_OFF_CTRL_TWO) begin
			return CMS_IDX_CTRL_TWO;
		end else if (addr == CMS_OFF_CTRL_ONE) begin
			return CMS_IDX_CTRL_ONE;
		end else if (addr == CMS_OFF_CTRL_THR) begin
			return CMS_IDX_CTRL_THR;
		end else begin
			return CMS_IDX_NONE;
		end
	endfunction : reg_index

	// Pins come from the analog and debug domains
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_sync <= 2'h0;
			dbg_sync <= 2'h0;
		end else begin
			osc_sync <= {osc_sync[0], osc_stable_pin};
			dbg_sync <= {dbg_sync[0], debug_active_pin};
		end
	end

	// Write channel capture: address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr       <= 8'h00;
			aw_full       <= 1'b0;
			s_axi_awready <= 1'b0;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			w_full        <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= CMS_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_full       <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!aw_full && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_full       <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!w_full && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (aw_full && w_full) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (reg_index(aw_addr) == CMS_IDX_NONE) ? CMS_RESP_SLVERR
				                                                      : CMS_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; only byte lane 0 carries data. Trim is never self-loaded.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			source_select        <= CMS_RST_SRC;
			reference_divider    <= CMS_RST_REFERENCE_DIVIDER;
			internal_ref_select  <= 1'b1;
			internal_ref_enable  <= 1'b0;
			bus_divider          <= CMS_RST_BUS_DIVIDER;
			osc_range_high       <= 1'b0;
			high_gain_oscillator <= 1'b0;
			low_power_bypass     <= 1'b0;
			crystal_select       <= 1'b0;
			external_ref_en      <= 1'b0;
			loop_select          <= 1'b0;
			loop_multiplier      <= CMS_RST_LOOP_MULTIPLIER;
			coarse_trim_value    <= CMS_RST_TRIM;
			fine_trim_bit        <= 1'b0;
		end else if (aw_full && w_full && w_strb[0]) begin
			case (reg_index(aw_addr))
				CMS_IDX_STATUS: begin
					fine_trim_bit <= w_data[CMS_FINE_TRIM_BIT_BIT];
				end
				CMS_IDX_TRIM: begin
					coarse_trim_value <= w_data[7:0];
				end
				CMS_IDX_CTRL_ONE: begin
					source_select       <= w_data[CMS_SRC_HI:CMS_SRC_LO];
					reference_divider   <= w_data[CMS_REFERENCE_DIVIDER_HI:CMS_REFERENCE_DIVIDER_LO];
					internal_ref_select <= w_data[CMS_IREF_BIT];
					internal_ref_enable <= w_data[CMS_IRCLK_BIT];
				end
				CMS_IDX_CTRL_TWO: begin
					bus_divider          <= w_data[CMS_BUS_DIVIDER_HI:CMS_BUS_DIVIDER_LO];
					osc_range_high       <= w_data[CMS_RANGE_BIT];
					high_gain_oscillator <= w_data[CMS_HGO_BIT];
					low_power_bypass     <= w_data[CMS_LP_BIT];
					crystal_select       <= w_data[CMS_XTAL_BIT];
					external_ref_en      <= w_data[CMS_EREN_BIT];
				end
				CMS_IDX_CTRL_THR: begin
					loop_select     <= w_data[CMS_LOOP_BIT];
					loop_multiplier <= w_data[CMS_LOOP_MULTIPLIER_HI:CMS_LOOP_MULTIPLIER_LO];
				end
				default: begin
				end
			endcase
		end
	end

	// Read channel: one word per read, answered the cycle after acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= CMS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= CMS_RESP_OKAY;
			s_axi_rdata   <= 32'h0;
			case (reg_index(s_axi_araddr))
				CMS_IDX_STATUS: begin
					s_axi_rdata[7:0] <= {1'b0, lock, loop_select_status, ref_status,
					                     source_status, oscillator_ready, fine_trim_bit};
				end
				CMS_IDX_TRIM: begin
					s_axi_rdata[7:0] <= coarse_trim_value;
				end
				CMS_IDX_CTRL_ONE: begin
					s_axi_rdata[7:0] <= {source_select, reference_divider, internal_ref_select,
					                     internal_ref_enable, 1'b0};
				end
				CMS_IDX_CTRL_TWO: begin
					s_axi_rdata[7:0] <= {bus_divider, osc_range_high, high_gain_oscillator,
					                     low_power_bypass, crystal_select, external_ref_en, 1'b0};
				end
				CMS_IDX_CTRL_THR: begin
					s_axi_rdata[7:0] <= {1'b0, loop_select, 2'h0, loop_multiplier};
				end
				default: begin
					s_axi_rresp <= CMS_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Low power is honoured only in the two bypass forms and never while debug runs
	always_comb begin
		lp_eff = low_power_bypass && !dbg_sync[1] &&
		         ((source_select == CMS_SRC_EXT && !internal_ref_select) ||
		          (source_select == CMS_SRC_INT && internal_ref_select && !loop_select));
		ext_on    = external_ref_en || !internal_ref_select || source_select == CMS_SRC_EXT;
		ext_avail = ext_on && (!crystal_select || oscillator_ready);
		ref_ok    = ref_status ? iref_stable : ext_avail;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oscillator_ready <= 1'b0;
		end else begin
			oscillator_ready <= ext_on && crystal_select && osc_sync[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iref_count  <= 12'h0;
			iref_stable <= 1'b0;
		end else if (iref_count == 12'(CMS_IREF_STAB_CYCLES - 1)) begin
			iref_stable <= 1'b1;
		end else begin
			iref_count <= iref_count + 12'h1;
		end
	end

	// Divider and loop changes wait while the loops are powered down
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			applied_reference_divider <= CMS_RST_REFERENCE_DIVIDER;
			applied_loop_multiplier <= CMS_RST_LOOP_MULTIPLIER;
			applied_loop <= 1'b0;
		end else if (!lp_eff) begin
			applied_reference_divider <= reference_divider;
			applied_loop_multiplier <= loop_multiplier;
			applied_loop <= loop_select;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loop_select_status <= 1'b0;
			fll_enable         <= 1'b0;
			pll_enable         <= 1'b0;
		end else begin
			loop_select_status <= applied_loop;
			// Enables follow the loop status on the same edge as the bypassed external modes; engaged modes change only after the source switch settles
			fll_enable         <= !lp_eff && !loop_select_status;
			pll_enable         <= !lp_eff && loop_select_status;
		end
	end

	// Reference switch holds the old reference until the new one is usable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_status <= 1'b1;
			ref_count  <= 8'h0;
		end else if (internal_ref_select == ref_status ||
		             !(internal_ref_select ? iref_stable : ext_avail)) begin
			ref_count <= 8'h0;
		end else if (ref_count == 8'(CMS_SRC_SWITCH_CYCLES - 1)) begin
			ref_status <= internal_ref_select;
			ref_count  <= 8'h0;
		end else begin
			ref_count <= ref_count + 8'h1;
		end
	end

	// Any change in what the loop locks to restarts acquisition
	assign lock_cfg = {applied_loop, ref_status, applied_reference_divider, applied_loop_multiplier};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock          <= 1'b0;
			lock_count    <= 24'h0;
			lock_cfg_prev <= 9'h0;
		end else begin
			lock_cfg_prev <= lock_cfg;
			if (lp_eff || !ref_ok || lock_cfg != lock_cfg_prev) begin
				lock       <= 1'b0;
				lock_count <= 24'h0;
			end else if (lock_count == 24'(LOCK_CYCLES - 1)) begin
				lock <= 1'b1;
			end else begin
				lock_count <= lock_count + 24'h1;
			end
		end
	end

	always_comb begin
		case (source_select)
			CMS_SRC_LOOP: begin
				next_target  = loop_select_status ? CMS_SRC_PLL : CMS_SRC_LOOP;
				target_avail = !lp_eff && ref_ok;
			end
			CMS_SRC_INT: begin
				next_target  = CMS_SRC_INT;
				target_avail = iref_stable;
			end
			CMS_SRC_EXT: begin
				next_target  = CMS_SRC_EXT;
				target_avail = ext_avail;
			end
			default: begin
				next_target  = source_status;
				target_avail = 1'b0;
			end
		endcase
	end

	// The output mux and its status change together after the new clock settles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_state      <= CMS_SW_IDLE;
			sw_count      <= 8'h0;
			sw_target     <= CMS_SRC_LOOP;
			source_status <= CMS_SRC_LOOP;
			active_source <= CMS_SRC_LOOP;
		end else begin
			case (sw_state)
				CMS_SW_IDLE: begin
					sw_count <= 8'h0;
					if (next_target != source_status && target_avail) begin
						sw_target <= next_target;
						sw_state  <= CMS_SW_SETTLE;
					end
				end
				CMS_SW_SETTLE: begin
					if (next_target != sw_target || !target_avail) begin
						sw_state <= CMS_SW_IDLE;
					end else if (sw_count == 8'(CMS_SRC_SWITCH_CYCLES - 1)) begin
						source_status <= sw_target;
						active_source <= sw_target;
						sw_state      <= CMS_SW_IDLE;
					end else begin
						sw_count <= sw_count + 8'h1;
					end
				end
				default: begin
					sw_state <= CMS_SW_IDLE;
				end
			endcase
		end
	end

	// Mode as actually running, reachable only through the documented paths
	always_comb begin
		r_factor = 11'h1 << applied_reference_divider;
		b_factor = 11'h1 << bus_divider;
		case (source_status)
			CMS_SRC_LOOP: begin
				next_mode = ref_status ? CMS_FLL_ENGAGED_INTERNAL : CMS_FLL_ENGAGED_EXTERNAL;
				next_mult = CMS_FLL_FACTOR;
				next_div  = ref_status ? b_factor : 11'(r_factor * b_factor);
			end
			CMS_SRC_PLL: begin
				next_mode = CMS_PLL_ENGAGED_EXTERNAL;
				next_mult = {5'h0, applied_loop_multiplier, 2'h0};
				next_div  = 11'(r_factor * b_factor);
			end
			CMS_SRC_INT: begin
				next_mode = lp_eff ? CMS_LOW_POWER_BYPASSED_INTERNAL : CMS_FLL_BYPASSED_INTERNAL;
				next_mult = 11'h1;
				next_div  = b_factor;
			end
			default: begin
				next_mode = lp_eff ? CMS_LOW_POWER_BYPASSED_EXTERNAL :
				            (loop_select_status ? CMS_PLL_BYPASSED_EXTERNAL
				                                : CMS_FLL_BYPASSED_EXTERNAL);
				next_mult = 11'h1;
				next_div  = b_factor;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_mode          <= CMS_FLL_ENGAGED_INTERNAL;
			freq_multiplier     <= CMS_FLL_FACTOR;
			freq_divisor        <= 11'(1 << CMS_RST_BUS_DIVIDER);
			bus_divisor         <= 12'(2 << CMS_RST_BUS_DIVIDER);
			external_ref_enable <= 1'b0;
		end else begin
			clock_mode          <= next_mode;
			freq_multiplier     <= next_mult;
			freq_divisor        <= next_div;
			bus_divisor         <= {next_div, 1'b0};
			external_ref_enable <= ext_on;
		end
	end
endmodule : cms_clock_mode_sequencer
`default_nettype wire

// ===== tb/cms_clock_mode_sequencer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cms_sequencer_sva
	import cms_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire cms_mode_t   clock_mode,
	input wire logic [1:0]  active_source,
	input wire logic [10:0] freq_multiplier,
	input wire logic [10:0] freq_divisor,
	input wire logic [11:0] bus_divisor,
	input wire logic        fll_enable,
	input wire logic        pll_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	// Entry cycles are skipped, though enables and mode update on the same edge
	sequence lp_held;
		(clock_mode == CMS_LOW_POWER_BYPASSED_EXTERNAL) [*3];
	endsequence
	reset_mode_a: assert property (
		$rose(aresetn) |-> clock_mode == CMS_FLL_ENGAGED_INTERNAL && bus_divisor == 12'h004)
		else $error("mode or bus divider wrong after reset");
	bus_half_a: assert property (
		bus_divisor == {freq_divisor, 1'b0}) else $error("bus divisor not twice output");
	lp_loops_off_a: assert property (
		lp_held |-> !fll_enable && !pll_enable) else $error("loop powered in low power");
	pll_source_a: assert property (
		active_source == CMS_SRC_PLL |-> pll_enable) else $error("pll source while pll off");
	fbe_fll_on_a: assert property (
		clock_mode == CMS_FLL_BYPASSED_EXTERNAL |-> fll_enable) else $error("fll off in bypass");
	fei_factor_a: assert property (
		clock_mode == CMS_FLL_ENGAGED_INTERNAL |-> freq_multiplier == CMS_FLL_FACTOR)
		else $error("fll factor wrong");
	bypass_unity_a: assert property (
		clock_mode inside {CMS_FLL_BYPASSED_INTERNAL, CMS_FLL_BYPASSED_EXTERNAL}
		|-> freq_multiplier == 11'h001) else $error("bypass multiplier not one");
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
	rdata_hold_a: assert property (
		rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	aw_block_a: assert property (
		s_axi_bvalid |-> !s_axi_awready) else $error("write taken while pending");
	ar_block_a: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while pending");
endmodule : cms_sequencer_sva
bind cms_clock_mode_sequencer cms_sequencer_sva i_cms_sequencer_sva (.*);
`default_nettype wire

// ===== tb/tb_cms_clock_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cms_clock_mode_sequencer
	import cms_pkg::*;
;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        osc_stable_pin = 1'b0, debug_active_pin = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, active_source, rsp, bdv;
	cms_mode_t   clock_mode;
	logic [10:0] freq_multiplier, freq_divisor;
	logic [11:0] bus_divisor;
	logic        fll_enable, pll_enable, internal_ref_enable, external_ref_enable;
	logic        crystal_select, high_gain_oscillator, osc_range_high, fine_trim_bit;
	logic [7:0]  coarse_trim_value, tv;
	logic [2:0]  rdv;
	logic [31:0] rst_tab [4] = '{32'h80, 32'h40, 32'h04, 32'h01};
	logic [2:0]  rcode [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
	int          err_count = 0, cmp_count = 0, seed = 32'h1ee850e7, i;
	bit          slow = 1'b0;

	always #25 aclk = ~aclk;

	cms_clock_mode_sequencer #(.LOCK_CYCLES(20)) i_cms_clock_mode_sequencer (.*);

	function automatic logic [11:0] exp_div(input logic [2:0] r, input logic [1:0] b);
		return 12'h001 << (int'(r) + int'(b));
	endfunction : exp_div

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic tmo;
		chk("handshake", 1, 0);
		summarize();
	endtask : tmo

	// Slow mode delays bready/rready so the hold checks see a waiting master
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n == 4) s_axi_bready <= 1'b1;
			if (n > 200) tmo();
		end while (!(s_axi_bvalid && s_axi_bready));
		chk("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == 4) s_axi_rready <= 1'b1;
			if (n > 200) tmo();
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rdr

	task automatic poll(input string n, input logic [7:0] m, input logic [7:0] v);
		int k;
		k = 0;
		do begin
			rdr(CMS_OFF_STATUS);
			k++;
			if (k > 1000) tmo();
		end while ((rd[7:0] & m) !== v);
		chk(n, v, rd[7:0] & m);
	endtask : poll

	task automatic wmode(input cms_mode_t m);
		int k;
		for (k = 0; k < 40 && clock_mode !== m; k++) @(posedge aclk);
		chk("clock_mode", m, clock_mode);
	endtask : wmode

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(CMS_OFF_STATUS);
		chk("status", 32'h10, rd & 32'hfe);
		for (i = 0; i < 4; i++) begin
			rdr(CMS_OFF_TRIM + 8'(i * 4));
			chk("reg_reset", rst_tab[i], rd & 32'hfd);
		end
		chk("mode", CMS_FLL_ENGAGED_INTERNAL, clock_mode);
		chk("bus_div", 12'h004, bus_divisor);
		tv = 8'($random(seed));
		wr(CMS_OFF_TRIM, tv, CMS_RESP_OKAY);
		rdr(CMS_OFF_TRIM);
		chk("trim", tv, rd);
		chk("trim_out", tv, coarse_trim_value);
		wr(CMS_OFF_STATUS, 8'h01, CMS_RESP_OKAY);
		chk("fine_trim", 1'b1, fine_trim_bit);
		wr(8'h20, 8'h55, CMS_RESP_SLVERR);
		rdr(8'h20);
		chk("unmapped_resp", CMS_RESP_SLVERR, rsp);
		chk("unmapped_data", 32'h0, rd);
		poll("lock", 8'h40, 8'h40);
		$display("test reset done");
		wr(CMS_OFF_CTRL_ONE, 8'h46, CMS_RESP_OKAY);
		poll("src_int", 8'h0c, 8'h04);
		chk("act_src", CMS_SRC_INT, active_source);
		chk("iref_en", 1'b1, internal_ref_enable);
		wmode(CMS_FLL_BYPASSED_INTERNAL);
		wr(CMS_OFF_CTRL_TWO, 8'h48, CMS_RESP_OKAY);
		wmode(CMS_LOW_POWER_BYPASSED_INTERNAL);
		debug_active_pin <= 1'b1;
		wmode(CMS_FLL_BYPASSED_INTERNAL);
		debug_active_pin <= 1'b0;
		// Crystal chosen while its pin is still low, so the external clock is unavailable
		wr(CMS_OFF_CTRL_TWO, 8'h44, CMS_RESP_OKAY);
		wr(CMS_OFF_CTRL_ONE, 8'h84, CMS_RESP_OKAY);
		repeat (20) @(posedge aclk);
		rdr(CMS_OFF_STATUS);
		chk("src_kept", CMS_SRC_INT, rd[3:2]);
		chk("act_kept", CMS_SRC_INT, active_source);
		wr(CMS_OFF_CTRL_ONE, 8'h44, CMS_RESP_OKAY);
		$display("test internal done");
		wr(CMS_OFF_CTRL_TWO, 8'h76, CMS_RESP_OKAY);
		repeat (10) @(posedge aclk);
		poll("osc_low", 8'h02, 8'h00);
		osc_stable_pin <= 1'b1;
		poll("osc", 8'h02, 8'h02);
		chk("ctl_two", 4'hf, {external_ref_enable, crystal_select, high_gain_oscillator,
		                      osc_range_high});
		wr(CMS_OFF_CTRL_ONE, 8'hb8, CMS_RESP_OKAY);
		poll("fbe", 8'h1c, 8'h08);
		wmode(CMS_FLL_BYPASSED_EXTERNAL);
		wr(CMS_OFF_CTRL_TWO, 8'h7e, CMS_RESP_OKAY);
		wmode(CMS_LOW_POWER_BYPASSED_EXTERNAL);
		wr(CMS_OFF_CTRL_ONE, 8'h90, CMS_RESP_OKAY);
		wr(CMS_OFF_CTRL_THR, 8'h44, CMS_RESP_OKAY);
		chk("loops_off", 2'b00, {fll_enable, pll_enable});
		poll("staged", 8'h20, 8'h00);
		wr(CMS_OFF_CTRL_TWO, 8'h76, CMS_RESP_OKAY);
		wmode(CMS_PLL_BYPASSED_EXTERNAL);
		poll("loop_pll", 8'h20, 8'h20);
		wr(CMS_OFF_CTRL_ONE, 8'h10, CMS_RESP_OKAY);
		poll("pee", 8'h0c, 8'h0c);
		wmode(CMS_PLL_ENGAGED_EXTERNAL);
		chk("mult", 11'h010, freq_multiplier);
		chk("div", 11'h008, freq_divisor);
		$display("test external done");
		for (i = 0; i < 12; i++) begin
			slow = i[0];
			rdv = rcode[i < 4 ? i : ($random(seed) & 3)];
			bdv = 2'($random(seed));
			wr(CMS_OFF_CTRL_TWO, {bdv, 6'h36}, CMS_RESP_OKAY);
			wr(CMS_OFF_CTRL_ONE, {2'b00, rdv, 3'b000}, CMS_RESP_OKAY);
			@(posedge aclk);
			chk("freq_div", exp_div(rdv, bdv), freq_divisor);
			chk("bus_div", {exp_div(rdv, bdv), 1'b0}, bus_divisor);
		end
		$display("test dividers done");
		wr(CMS_OFF_CTRL_ONE, 8'hb8, CMS_RESP_OKAY);
		poll("pbe", 8'h0c, 8'h08);
		wmode(CMS_PLL_BYPASSED_EXTERNAL);
		wr(CMS_OFF_CTRL_THR, 8'h04, CMS_RESP_OKAY);
		poll("loop_fll", 8'h20, 8'h00);
		wmode(CMS_FLL_BYPASSED_EXTERNAL);
		wr(CMS_OFF_CTRL_ONE, 8'h38, CMS_RESP_OKAY);
		poll("fee", 8'h1c, 8'h00);
		wmode(CMS_FLL_ENGAGED_EXTERNAL);
		chk("fee_mult", CMS_FLL_FACTOR, freq_multiplier);
		chk("fee_div", exp_div(3'h7, bdv), freq_divisor);
		$display("test engaged external done");
		summarize();
	end
endmodule : tb_cms_clock_mode_sequencer
`default_nettype wire
